/* File: design/dead_time.v */
// dead-time inserter for one complementary pair
`timescale 1ns/100ps
module dead_time (
  input wire CLK,
  input wire SYS_RST,
  input wire CE,
  input wire ENABLE,
  input wire [7:0] DELAY_CYC,
  input wire REQ_A,
  input wire REQ_B,
  output reg OUT_A,
  output reg OUT_B
);
  reg [7:0] cnt_reg; // cycles both outputs have been low
  // outputs rise only after both were low for the delay
  always @(posedge CLK) begin
    if (SYS_RST) begin
      OUT_A <= 1'b0;
      OUT_B <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (CE) begin
      if (!REQ_A) OUT_A <= 1'b0;
      if (!REQ_B) OUT_B <= 1'b0;
      if (!ENABLE) begin
        OUT_A <= REQ_A;
        OUT_B <= REQ_B;
        cnt_reg <= 8'h00;
      end else if (OUT_A || OUT_B) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg < DELAY_CYC) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else begin
        OUT_A <= REQ_A && !REQ_B;
        OUT_B <= REQ_B && !REQ_A;
      end
    end
  end
endmodule // dead_time

/* File: design/gate_driver_ctrl.v */
// gate driver control logic with axi4-lite registers
`timescale 1ns/100ps
`include "gate_driver_consts.vh"
module gate_driver_ctrl (
  input wire CLK,
  input wire SYS_RST,
  input wire CE,
  input wire CTRL_IN_A,
  input wire CTRL_IN_B,
  input wire ENABLE_IN,
  input wire SUPPLY_IN_ABOVE_RISE,
  input wire SUPPLY_IN_ABOVE_FALL,
  input wire SUPPLY_A_ABOVE_RISE,
  input wire SUPPLY_A_ABOVE_FALL,
  input wire SUPPLY_B_ABOVE_RISE,
  input wire SUPPLY_B_ABOVE_FALL,
  output reg GATE_OUT_A,
  output reg GATE_OUT_B,
  output reg READY,
  output wire IRQ,
  input wire [11:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [11:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  // state codes of the input-side power sequencer
  localparam [1:0] ST_LOCK = 2'd0; // input lockout
  localparam [1:0] ST_HOLD = 2'd1; // waiting start hold time
  localparam [1:0] ST_SAFE = 2'd2; // waiting safe startup delay
  localparam [1:0] ST_RUN = 2'd3; // outputs follow inputs
  localparam integer START_CYC_I = `START_HOLD_CYC;
  localparam integer SAFE_CYC_I = `SAFE_STARTUP_CYC;
  localparam integer SD_CYC_I = `SHUTDOWN_CYC;
  localparam integer RS_CYC_I = `RESTART_CYC;
  localparam [13:0] START_CYC = START_CYC_I[13:0];
  localparam [13:0] SAFE_CYC = SAFE_CYC_I[13:0];
  localparam [7:0] SD_CYC = SD_CYC_I[7:0];
  localparam [7:0] RS_CYC = RS_CYC_I[7:0];
  localparam [31:0] RES_MIN = `DT_RES_MIN_KOHM; // clamp bounds of the resistance
  localparam [31:0] RES_MAX = `DT_RES_MAX_KOHM;
  localparam [31:0] RES_INIT = `DEAD_RES_RESET;

  // decode one word offset into a register select
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `REG_CTRL: reg_sel = 3'd0;
        `REG_STATUS: reg_sel = 3'd1;
        `REG_IRQ_STAT: reg_sel = 3'd2;
        `REG_IRQ_MASK: reg_sel = 3'd3;
        `REG_DEAD_RES: reg_sel = 3'd4;
        default: reg_sel = 3'd7;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronised, optionally filtered inputs
  reg [31:0] ctrl_reg; // mode control
  reg [6:0] dead_res_reg; // programming resistance in kilohm
  wire [8:0] raw_in; // raw pin inputs
  wire [8:0] syn_in; // synchronised inputs
  wire [8:0] filt_en; // filter only the logic inputs
  assign raw_in = {SUPPLY_B_ABOVE_FALL, SUPPLY_B_ABOVE_RISE, SUPPLY_A_ABOVE_FALL, SUPPLY_A_ABOVE_RISE,
                   SUPPLY_IN_ABOVE_FALL, SUPPLY_IN_ABOVE_RISE, ENABLE_IN, CTRL_IN_B, CTRL_IN_A};
  assign filt_en = {6'h00, {3{ctrl_reg[`CTRL_DEGLITCH]}}};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_sync
      // synchronise every input, deglitch the logic ones
      sync_filter u_sync (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .CE(CE),
        .D(raw_in[gi]),
        .FILTER_EN(filt_en[gi]),
        .Q(syn_in[gi])
      );
    end
  endgenerate
  wire in_a = syn_in[0];
  wire in_b = syn_in[1];
  wire en_in = syn_in[2];

  ////////////////////////////////////////////////////////////////////////
  // lockout monitors with hysteresis
  reg lock_i_reg; // input-side lockout
  reg lock_a_reg; // channel a lockout
  reg lock_b_reg; // channel b lockout
  always @(posedge CLK) begin
    if (SYS_RST) begin
      lock_i_reg <= 1'b1;
      lock_a_reg <= 1'b1;
      lock_b_reg <= 1'b1;
    end else if (CE) begin
      if (!syn_in[4]) lock_i_reg <= 1'b1;
      else if (syn_in[3]) lock_i_reg <= 1'b0;
      if (!syn_in[6]) lock_a_reg <= 1'b1;
      else if (syn_in[5]) lock_a_reg <= 1'b0;
      if (!syn_in[8]) lock_b_reg <= 1'b1;
      else if (syn_in[7]) lock_b_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power sequencer: start hold then optional safe delay
  reg [1:0] state_reg;
  reg [13:0] seq_cnt_reg;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_LOCK;
      seq_cnt_reg <= 14'h0000;
    end else if (CE) begin
      if (lock_i_reg) begin
        // input lockout restarts the sequence
        state_reg <= ST_LOCK;
        seq_cnt_reg <= 14'h0000;
      end else begin
        case (state_reg)
          ST_LOCK: begin
            state_reg <= ST_HOLD;
            seq_cnt_reg <= 14'h0000;
          end
          ST_HOLD: begin
            if (seq_cnt_reg >= START_CYC - 14'h0001) begin
              state_reg <= ctrl_reg[`CTRL_DELAY_START] ? ST_SAFE : ST_RUN;
              seq_cnt_reg <= 14'h0000;
            end else begin
              seq_cnt_reg <= seq_cnt_reg + 14'h0001;
            end
          end
          ST_SAFE: begin
            if (seq_cnt_reg >= SAFE_CYC - 14'h0001) begin
              state_reg <= ST_RUN;
            end else begin
              seq_cnt_reg <= seq_cnt_reg + 14'h0001;
            end
          end
          ST_RUN: state_reg <= ST_RUN;
          default: state_reg <= ST_LOCK;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable path: stop after shutdown time, resume after restart time
  reg en_act_reg; // effective enable
  reg [7:0] en_cnt_reg;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      en_act_reg <= 1'b0;
      en_cnt_reg <= 8'h00;
    end else if (CE) begin
      if (en_in == en_act_reg) begin
        en_cnt_reg <= 8'h00;
      end else if (en_cnt_reg >= (en_in ? RS_CYC : SD_CYC) - 8'h01) begin
        en_act_reg <= en_in;
        en_cnt_reg <= 8'h00;
      end else begin
        en_cnt_reg <= en_cnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // requested gate levels
  reg req_a;
  reg req_b;
  always @* begin
    if (ctrl_reg[`CTRL_PWM_MODE]) begin
      req_a = in_a;
      req_b = !in_a;
    end else begin
      req_a = in_a;
      req_b = in_b;
    end
    if (state_reg != ST_RUN || lock_i_reg || !en_act_reg) begin
      // lockout overrides enable; enable low drives both low
      req_a = 1'b0;
      req_b = 1'b0;
    end
    if (ctrl_reg[`CTRL_ENH_UNDERVOLTAGE_LOCKOUT] && (lock_a_reg || lock_b_reg)) begin
      req_a = 1'b0;
      req_b = 1'b0;
    end
  end

  // dead time cycles from resistance: ns*100 = 197*r + 275
  wire [31:0] dt_x100 = dead_res_reg * `DT_SLOPE_X100 + `DT_OFFSET_X100;
  wire [31:0] dt_div = (dt_x100 + `CLK_PERIOD_NS * 100 - 1) / (`CLK_PERIOD_NS * 100);
  wire [7:0] dt_cyc = dt_div[7:0]; // at most two cycles over the whole range
  wire dt_a;
  wire dt_b;
  // delays the rising edge of each output in pwm mode with CTRL_DEAD_EN set; falling edges pass at once
  dead_time u_dead (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .CE(CE),
    .ENABLE(ctrl_reg[`CTRL_PWM_MODE] && ctrl_reg[`CTRL_DEAD_EN]),
    .DELAY_CYC(dt_cyc),
    .REQ_A(req_a),
    .REQ_B(req_b),
    .OUT_A(dt_a),
    .OUT_B(dt_b)
  );

  // gate outputs, channel lockout gates its own output
  always @(posedge CLK) begin
    if (SYS_RST) begin
      GATE_OUT_A <= 1'b0;
      GATE_OUT_B <= 1'b0;
      READY <= 1'b0;
    end else if (CE) begin
      GATE_OUT_A <= dt_a && !lock_a_reg && !lock_i_reg;
      GATE_OUT_B <= dt_b && !lock_b_reg && !lock_i_reg;
      READY <= !lock_i_reg && !lock_a_reg && !lock_b_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt events
  reg [`EVT_W-1:0] irq_stat_reg;
  reg [`EVT_W-1:0] irq_mask_reg;
  reg ready_d_reg;
  reg [2:0] lock_d_reg;
  wire [`EVT_W-1:0] evt;
  assign evt = {lock_b_reg & ~lock_d_reg[2], lock_a_reg & ~lock_d_reg[1], lock_i_reg & ~lock_d_reg[0],
                ready_d_reg & ~READY, READY & ~ready_d_reg};
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read at a time
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  assign S_AXI_AWREADY = !aw_hold_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_hold_reg && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire aw_ok = aw_hold_reg || (S_AXI_AWVALID && S_AXI_AWREADY);
  wire w_ok = w_hold_reg || (S_AXI_WVALID && S_AXI_WREADY);
  wire [11:0] wr_addr = aw_hold_reg ? awaddr_reg : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold_reg ? wdata_reg : S_AXI_WDATA;
  wire do_wr = aw_ok && w_ok && !S_AXI_BVALID;
  wire do_rd = S_AXI_ARVALID && S_AXI_ARREADY;
  wire rd_stat = do_rd && reg_sel(S_AXI_ARADDR) == 3'd2;

  // write channel and register updates
  always @(posedge CLK) begin
    if (SYS_RST) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
      dead_res_reg <= RES_INIT[6:0];
      irq_mask_reg <= {`EVT_W{1'b0}};
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY && !do_wr) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY && !do_wr) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
      end
      if (do_wr) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `RESP_OKAY;
        case (reg_sel(wr_addr))
          3'd0: ctrl_reg <= {27'h000_0000, wr_data[4:0]};
          3'd3: irq_mask_reg <= wr_data[`EVT_W-1:0];
          3'd4: begin
            // clamp to the permitted resistance range
            // compare the whole word so large values clamp instead of wrapping
            if (wr_data < RES_MIN) dead_res_reg <= RES_MIN[6:0];
            else if (wr_data > RES_MAX) dead_res_reg <= RES_MAX[6:0];
            else dead_res_reg <= wr_data[6:0];
          end
          3'd1, 3'd2: S_AXI_BRESP <= `RESP_OKAY;
          default: S_AXI_BRESP <= `RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // read channel, status clear on read with set winning
  always @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
      irq_stat_reg <= {`EVT_W{1'b0}};
      ready_d_reg <= 1'b0;
      lock_d_reg <= 3'b111;
    end else if (CE) begin
      ready_d_reg <= READY;
      lock_d_reg <= {lock_b_reg, lock_a_reg, lock_i_reg};
      irq_stat_reg <= (rd_stat ? {`EVT_W{1'b0}} : irq_stat_reg) | evt;
      if (do_rd) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `RESP_OKAY;
        case (reg_sel(S_AXI_ARADDR))
          3'd0: S_AXI_RDATA <= ctrl_reg;
          3'd1: S_AXI_RDATA <= {25'h000_0000, state_reg, en_act_reg, lock_b_reg, lock_a_reg, lock_i_reg, READY};
          3'd2: S_AXI_RDATA <= {27'h000_0000, irq_stat_reg};
          3'd3: S_AXI_RDATA <= {27'h000_0000, irq_mask_reg};
          3'd4: S_AXI_RDATA <= {25'h000_0000, dead_res_reg};
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // gate_driver_ctrl

/* File: design/sync_filter.v */
// two-stage synchroniser followed by an optional glitch filter
`timescale 1ns/100ps
`include "gate_driver_consts.vh"
module sync_filter (
  input wire CLK,
  input wire SYS_RST,
  input wire CE,
  input wire D,
  input wire FILTER_EN,
  output reg Q
);
  reg meta_reg; // first stage, read only by second stage
  reg sync_reg; // second stage
  reg [1:0] cnt_reg; // stable-cycle counter
  localparam integer DG_CYC_I = `DEGLITCH_CYC;
  localparam [1:0] DG_LIM = DG_CYC_I[1:0]; // extra cycles a change must hold
  // synchroniser stages
  always @(posedge CLK) begin
    if (SYS_RST) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (CE) begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end
  // filter: pass a change only after it held for the deglitch window
  always @(posedge CLK) begin
    if (SYS_RST) begin
      Q <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (CE) begin
      if (sync_reg == Q) begin
        cnt_reg <= 2'h0;
      end else if (!FILTER_EN || cnt_reg >= DG_LIM) begin
        Q <= sync_reg;
        cnt_reg <= 2'h0;
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule // sync_filter

/* File: include/gate_driver_consts.vh */
// timing counts, variant codes and register map for the gate driver control
`ifndef GATE_DRIVER_CONSTS_VH
`define GATE_DRIVER_CONSTS_VH
// clock period in ns (10 MHz)
`define CLK_PERIOD_NS 100
// timing figures in their own unit
`define START_HOLD_NS 1000
`define SHUTDOWN_NS 200
`define RESTART_NS 200
`define SAFE_STARTUP_US 1000
`define DEGLITCH_NS 30
// dead time equation: ns = 1.97 * kohm + 2.75, held in hundredths
`define DT_SLOPE_X100 197
`define DT_OFFSET_X100 275
`define DT_RES_MIN_KOHM 6
`define DT_RES_MAX_KOHM 100
// derived cycle counts: least times round up, longest times round down, at least one
`define START_HOLD_CYC ((`START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHUTDOWN_CYC (((`SHUTDOWN_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`SHUTDOWN_NS / `CLK_PERIOD_NS))
`define RESTART_CYC (((`RESTART_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`RESTART_NS / `CLK_PERIOD_NS))
`define SAFE_STARTUP_CYC ((`SAFE_STARTUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// register byte offsets
`define REG_CTRL 12'h0000
`define REG_STATUS 12'h0004
`define REG_IRQ_STAT 12'h0008
`define REG_IRQ_MASK 12'h000C
`define REG_DEAD_RES 12'h0010
// control register fields
`define CTRL_PWM_MODE 0
`define CTRL_ENH_UNDERVOLTAGE_LOCKOUT 1
`define CTRL_DELAY_START 2
`define CTRL_DEAD_EN 3
`define CTRL_DEGLITCH 4
`define CTRL_RESET 32'h0000_0000
`define DEAD_RES_RESET 32'h0000_0006
// event bits: 0 ready rose, 1 ready fell, 2 input lockout, 3 lockout a, 4 lockout b
`define EVT_W 5
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: verification/gate_driver_ctrl_asserts.sv */
// port checker for the gate driver control block
`timescale 1ns/100ps
module gate_driver_ctrl_asserts (
  input wire CLK,
  input wire SYS_RST,
  input wire ENABLE_IN,
  input wire SUPPLY_IN_ABOVE_FALL,
  input wire SUPPLY_A_ABOVE_FALL,
  input wire SUPPLY_B_ABOVE_FALL,
  input wire GATE_OUT_A,
  input wire GATE_OUT_B,
  input wire READY,
  input wire IRQ,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID
);
  // one clock domain, reset disables every check
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  a_input_lock_low: assert property (!SUPPLY_IN_ABOVE_FALL [*6] |-> !GATE_OUT_A && !GATE_OUT_B)
    else $error("gate high while input supply low");
  a_enable_stops: assert property (!ENABLE_IN [*8] |-> !GATE_OUT_A && !GATE_OUT_B)
    else $error("gate high while enable low");
  a_ready_needs_supply: assert property ((!SUPPLY_IN_ABOVE_FALL || !SUPPLY_A_ABOVE_FALL || !SUPPLY_B_ABOVE_FALL) [*6]
    |-> !READY)
    else $error("ready high with a supply low");
  a_lock_a_low: assert property (!SUPPLY_A_ABOVE_FALL [*6] |-> !GATE_OUT_A)
    else $error("gate a high while its supply low");
  a_lock_b_low: assert property (!SUPPLY_B_ABOVE_FALL [*6] |-> !GATE_OUT_B)
    else $error("gate b high while its supply low");
  a_start_hold: assert property (!SUPPLY_IN_ABOVE_FALL [*6] ##1 SUPPLY_IN_ABOVE_FALL
    |-> (!GATE_OUT_A && !GATE_OUT_B) [*8])
    else $error("gate driven during start hold");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
    else $error("write response late");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read response late");
  // main scenarios reached
  cover property ($rose(READY));
  cover property ($rose(IRQ));
  cover property (GATE_OUT_A && !GATE_OUT_B);
endmodule // gate_driver_ctrl_asserts

bind gate_driver_ctrl gate_driver_ctrl_asserts i_chk (
  .CLK, .SYS_RST, .ENABLE_IN, .SUPPLY_IN_ABOVE_FALL, .SUPPLY_A_ABOVE_FALL, .SUPPLY_B_ABOVE_FALL,
  .GATE_OUT_A, .GATE_OUT_B, .READY, .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID
);

/* File: verification/gate_driver_ctrl_tb.sv */
// self-checking bench for the gate driver control block
`timescale 1ns/100ps
`include "gate_driver_consts.vh"
module gate_driver_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sir = 1'b0, sif = 1'b0, sar = 1'b0, saf = 1'b0, sbr = 1'b0, sbf = 1'b0; // supply monitors
  logic ovr = 1'b0, w_en = 1'b0, w_a = 1'b0, w_b = 1'b0; // controller requests
  logic en, ca, cb, ga, gb, rdy, irq;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int error_cnt = 0, cmp_count = 0;
  // dead time in cycles for a 100 kohm resistor, rounded up
  int dt_cyc = (`DT_SLOPE_X100 * 100 + `DT_OFFSET_X100 + 100 * `CLK_PERIOD_NS - 1) / (100 * `CLK_PERIOD_NS);

  initial begin
    forever #50 clk = ~clk;
  end

  gate_driver_ctrl i_dut (.CLK(clk), .SYS_RST(rst), .CE(1'b1), .CTRL_IN_A(ca), .CTRL_IN_B(cb), .ENABLE_IN(en),
    .SUPPLY_IN_ABOVE_RISE(sir), .SUPPLY_IN_ABOVE_FALL(sif), .SUPPLY_A_ABOVE_RISE(sar), .SUPPLY_A_ABOVE_FALL(saf),
    .SUPPLY_B_ABOVE_RISE(sbr), .SUPPLY_B_ABOVE_FALL(sbf), .GATE_OUT_A(ga), .GATE_OUT_B(gb), .READY(rdy), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  sys_ctrl_model i_ctl (.CLK(clk), .SYS_RST(rst), .READY(rdy), .OVERRIDE(ovr), .WANT_EN(w_en), .WANT_A(w_a),
    .WANT_B(w_b), .ENABLE_OUT(en), .CTRL_A_OUT(ca), .CTRL_B_OUT(cb));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results;
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // a bounded wait that ran out ends the run
  task automatic bail(input string nm);
    $display("[FAIL] %s expected done seen timeout", nm);
    error_cnt++;
    results();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // register bus master: address and data together, ready held until answer
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) bail("write_response");
    chk_word("write_resp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) bail("read_response");
    chk_word("read_data", e, rdata);
    chk_word("read_resp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // supply monitor levels: in rise, in fall, a rise, a fall, b rise, b fall
  task automatic sup(input logic [5:0] v);
    {sir, sif, sar, saf, sbr, sbf} <= v;
    @(posedge clk);
  endtask

  // controller request: enable, input a, input b
  task automatic req(input logic [2:0] v);
    {w_en, w_a, w_b} <= v;
    @(posedge clk);
  endtask

  task automatic wait_outs(input logic ea, input logic eb, input int lim);
    int n;
    for (n = 0; n < lim && !(ga === ea && gb === eb); n++) @(posedge clk);
    if (n == lim) bail("gate_outputs");
    chk_bit("gate_out_a", ea, ga);
    chk_bit("gate_out_b", eb, gb);
  endtask

  // count cycles in which any gate is seen high
  task automatic hold_low(input int cyc);
    int n;
    int bad;
    bad = 0;
    for (n = 0; n < cyc; n++) begin
      @(posedge clk);
      if (ga !== 1'b0 || gb !== 1'b0) bad++;
    end
    chk_word("gate_high_cycles", 32'h0000_0000, bad);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset values, clamping and an unmapped address
  task automatic t_regs;
    axi_rd(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
    axi_rd(`REG_DEAD_RES, `DEAD_RES_RESET, `RESP_OKAY);
    axi_rd(`REG_IRQ_MASK, 32'h0000_0000, `RESP_OKAY);
    axi_rd(12'h020, 32'h0000_0000, `RESP_SLVERR);
    axi_wr(12'h020, 32'h0000_0001, `RESP_SLVERR);
    axi_wr(`REG_DEAD_RES, 32'h0000_00C8, `RESP_OKAY);
    axi_rd(`REG_DEAD_RES, 32'h0000_0064, `RESP_OKAY);
    axi_wr(`REG_DEAD_RES, 32'h0000_0003, `RESP_OKAY);
    axi_rd(`REG_DEAD_RES, 32'h0000_0006, `RESP_OKAY);
    chk_bit("ready", 1'b0, rdy);
    wait_outs(1'b0, 1'b0, 1);
  endtask

  // power-up hold, then every dual input pattern
  task automatic t_startup;
    int n;
    int i;
    req(3'b111);
    sup(6'h3F);
    for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge clk);
    if (n == 20) bail("ready");
    hold_low(8);
    wait_outs(1'b1, 1'b1, 20);
    for (i = 0; i < 4; i++) begin
      req({1'b1, i[1:0]});
      wait_outs(i[1], i[0], 12);
    end
  endtask

  task automatic t_enable;
    req(3'b011);
    wait_outs(1'b0, 1'b0, 10);
    req(3'b111);
    wait_outs(1'b1, 1'b1, 10);
  endtask

  // cycles from one gate falling to the other rising
  task automatic dead(input logic p);
    int n;
    int g;
    g = 0;
    req({1'b1, p, 1'b0});
    for (n = 0; n < 20 && (p ? gb : ga) !== 1'b0; n++) @(posedge clk);
    if (n == 20) bail("dead_time_fall");
    for (n = 0; n < 20 && (p ? ga : gb) !== 1'b1; n++) begin
      @(posedge clk);
      g++;
    end
    if (n == 20) bail("dead_time_rise");
    chk_bit("dead_time_met", 1'b1, g >= dt_cyc);
  endtask

  // a one-cycle dip on input a is filtered out, a held one passes
  task automatic t_glitch;
    int n;
    int bad;
    bad = 0;
    axi_wr(`REG_CTRL, 32'h0000_0010, `RESP_OKAY);
    req(3'b101);
    req(3'b111);
    for (n = 0; n < 10; n++) begin
      @(posedge clk);
      if (ga !== 1'b1) bad++;
    end
    chk_word("glitch_low_cycles", 32'h0000_0000, bad);
    req(3'b101);
    wait_outs(1'b0, 1'b1, 12);
  endtask

  task automatic t_pwm;
    axi_wr(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
    req(3'b110);
    wait_outs(1'b1, 1'b0, 12);
    req(3'b100);
    wait_outs(1'b0, 1'b1, 12);
    axi_wr(`REG_DEAD_RES, 32'h0000_0064, `RESP_OKAY);
    axi_wr(`REG_CTRL, 32'h0000_0009, `RESP_OKAY);
    dead(1'b1);
    dead(1'b0);
  endtask

  // channel lockouts with the interrupt path; the controller keeps driving
  task automatic t_lock;
    axi_wr(`REG_CTRL, 32'h0000_0000, `RESP_OKAY);
    axi_wr(`REG_IRQ_MASK, 32'h0000_0008, `RESP_OKAY);
    ovr <= 1'b1;
    req(3'b111);
    wait_outs(1'b1, 1'b1, 12);
    axi_rd(`REG_IRQ_STAT, 32'h0000_0001, `RESP_OKAY);
    sup(6'h33);
    wait_outs(1'b0, 1'b1, 12);
    chk_bit("ready", 1'b0, rdy);
    chk_bit("irq", 1'b1, irq);
    axi_rd(`REG_IRQ_STAT, 32'h0000_000A, `RESP_OKAY);
    chk_bit("irq", 1'b0, irq);
    sup(6'h3F);
    wait_outs(1'b1, 1'b1, 30);
    chk_bit("irq_masked", 1'b0, irq);
    axi_wr(`REG_CTRL, 32'h0000_0002, `RESP_OKAY);
    sup(6'h3C);
    wait_outs(1'b0, 1'b0, 12);
    sup(6'h3F);
    wait_outs(1'b1, 1'b1, 30);
  endtask

  // input lockout with enable held high, exit only above the rising level
  task automatic t_hyst;
    sup(6'h0F);
    wait_outs(1'b0, 1'b0, 12);
    sup(6'h1F);
    hold_low(30);
    chk_bit("ready", 1'b0, rdy);
    sup(6'h3F);
    wait_outs(1'b1, 1'b1, 40);
  endtask

  task automatic t_delay;
    axi_wr(`REG_CTRL, 32'h0000_0004, `RESP_OKAY);
    sup(6'h0F);
    wait_outs(1'b0, 1'b0, 12);
    sup(6'h3F);
    hold_low(`SAFE_STARTUP_CYC - 50);
    wait_outs(1'b1, 1'b1, 200);
    ovr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_startup();
    t_enable();
    t_glitch();
    t_pwm();
    t_lock();
    t_hyst();
    t_delay();
    results();
  end
endmodule // gate_driver_ctrl_tb

/* File: verification/sys_ctrl_model.sv */
// system controller model driving the control and enable pins
`timescale 1ns/100ps
module sys_ctrl_model (
  input wire CLK,
  input wire SYS_RST,
  input wire READY,
  input wire OVERRIDE,
  input wire WANT_EN,
  input wire WANT_A,
  input wire WANT_B,
  output reg ENABLE_OUT,
  output reg CTRL_A_OUT,
  output reg CTRL_B_OUT
);
  ////////////////////////////////////////////////////////////////////////////////
  // pins stay quiet until ready, unless the bench orders a lockout stress
  always @(posedge CLK) begin
    if (SYS_RST || !(READY || OVERRIDE)) begin
      ENABLE_OUT <= 1'b0;
      CTRL_A_OUT <= 1'b0;
      CTRL_B_OUT <= 1'b0;
    end else begin
      ENABLE_OUT <= WANT_EN;
      CTRL_A_OUT <= WANT_A;
      CTRL_B_OUT <= WANT_B;
    end
  end
endmodule // sys_ctrl_model
